// ---- hdl/clocked_serial_port_control.sv ----
// Clocked serial port: register slave, shift clock generation or capture, and transfer control.
`timescale 1ns/1ps
`default_nettype none
module clocked_serial_port_control (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Interrupt
  output logic             irq_o,
  // Serial link
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe_n_o,
  input  wire logic        sdi_i,
  output logic             sdo_o
);

  typedef enum logic {ST_IDLE, ST_RUN} state_t;

  state_t             state;
  csp_pkg::ctrl_t     ctrl;
  csp_pkg::link_in_t  link_meta;
  csp_pkg::link_in_t  link_sync;
  logic               norm_d;
  logic               ack;
  logic               armed;
  logic               done_flag;
  logic               phase;
  logic [15:0]        div_cnt;
  logic [2:0]         bit_cnt;
  logic [7:0]         shift_data;

  // Pin synchronisers; only the second stage is read by logic.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      link_meta <= '1;
      link_sync <= '1;
    end
    else
    begin
      link_meta <= {sclk_i, sdi_i};
      link_sync <= link_meta;
    end
  end

  // Bus decode. Every access waits one cycle, so read data are registered beforehand.
  wire       req        = avs_read_i | avs_write_i;
  wire       take       = req & ack;
  wire       sel_low    = avs_address_i == csp_pkg::ADDR_DATA_LOW;
  wire       sel_high   = avs_address_i == csp_pkg::ADDR_DATA_HIGH;
  wire       sel_ctrl   = avs_address_i == csp_pkg::ADDR_CONTROL;
  wire       sel_flags  = avs_address_i == csp_pkg::ADDR_FLAGS;
  wire       sel_trig   = avs_address_i == csp_pkg::ADDR_TRIGGER;
  wire       wr_ok      = take & avs_write_i & avs_byteenable_i[0];
  wire       busy       = state == ST_RUN;
  wire       data_touch = take & (sel_low | sel_high);
  wire       flag_read  = take & avs_read_i & sel_flags;
  wire       trig_write = wr_ok & sel_trig & avs_writedata_i[csp_pkg::TRIGGER_BIT];
  wire       start      = trig_write & armed & ~busy;
  wire       abort      = flag_read & busy;
  wire       ext_clk    = {ctrl.src_high, ctrl.src_low} == csp_pkg::SRC_EXTERNAL;

  assign avs_waitrequest_o = req & ~ack;

  wire [3:0] rd_mux = sel_low   ? shift_data[3:0] :
                      sel_high  ? shift_data[7:4] :
                      sel_ctrl  ? ctrl :
                      sel_flags ? {3'h0, done_flag} :
                      sel_trig  ? {3'h0, busy} : 4'h0;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= req & ~ack;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      avs_readdata_o <= 32'h0000_0000;
    end
    else if (avs_read_i & ~ack)
    begin
      avs_readdata_o <= {28'h000_0000, rd_mux};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ctrl <= csp_pkg::CONTROL_RESET;
    end
    else if (wr_ok & sel_ctrl)
    begin
      ctrl <= avs_writedata_i[3:0];
    end
  end

  // Master half period follows the clock source select.
  wire [15:0] half_div = ctrl.src_high ? csp_pkg::HALF_DIV_SLOW :
                         ctrl.src_low  ? csp_pkg::HALF_DIV_MID  : csp_pkg::HALF_DIV_FAST;
  wire        tick     = busy & ~ext_clk & (div_cnt == 16'h0000);

  always_ff @(posedge clk_i)
  begin
    if (srst_i | ~busy | tick)
    begin
      div_cnt <= half_div - 16'h0001;
    end
    else
    begin
      div_cnt <= div_cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i | ~busy)
    begin
      phase <= 1'b1;
    end
    else if (tick)
    begin
      phase <= ~phase;
    end
  end

  // Edge select flips the polarity; a low-going normalised edge shifts out, high-going samples.
  wire norm       = link_sync.sclk ^ ctrl.edge_sel;
  wire ext_lead   = norm_d & ~norm;
  wire ext_trail  = ~norm_d & norm;
  wire lead_edge  = busy & (ext_clk ? ext_lead : (tick & phase));
  wire trail_edge = busy & (ext_clk ? ext_trail : (tick & ~phase));
  wire last_bit   = trail_edge & (bit_cnt == 3'h7) & ~abort;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      norm_d <= 1'b1;
    end
    else
    begin
      norm_d <= norm;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      unique case (state)
        ST_IDLE: if (start) state <= ST_RUN;
        ST_RUN:  if (abort | last_bit) state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i | data_touch | ~busy)
    begin
      bit_cnt <= 3'h0;
    end
    else if (trail_edge)
    begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // A data access arms the port, and the run that it starts uses the arming up.
  always_ff @(posedge clk_i)
  begin
    if (srst_i | start)
    begin
      armed <= 1'b0;
    end
    else if (data_touch & ~busy)
    begin
      armed <= 1'b1;
    end
  end

  // Only the value the reader was shown is cleared, and a new completion wins over the clear.
  wire flag_seen = flag_read & avs_readdata_o[csp_pkg::FLAG_DONE_BIT];

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      done_flag <= 1'b0;
    end
    else
    begin
      done_flag <= last_bit | (done_flag & ~flag_seen);
    end
  end

  assign irq_o = done_flag & ctrl.done_mask;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sclk_o      <= 1'b1;
      sclk_oe_n_o <= 1'b1;
    end
    else
    begin
      sclk_o      <= phase ^ ctrl.edge_sel;
      sclk_oe_n_o <= ext_clk;
    end
  end

  serial_shift_reg #(
    .WIDTH (8)
  ) u_shift (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .load_low_i  (wr_ok & sel_low),
    .load_high_i (wr_ok & sel_high),
    .nibble_i    (avs_writedata_i[3:0]),
    .out_step_i  (lead_edge | start),
    .sample_i    (trail_edge),
    .sdi_i       (link_sync.sdi),
    .data_o      (shift_data),
    .sdo_o       (sdo_o)
  );

endmodule : clocked_serial_port_control
`default_nettype wire

// ---- hdl/csp_pkg.sv ----
// Package with register map, field layout, reset values and timing counts of the serial port.
package csp_pkg;

  // Byte addresses of the word-aligned registers on the register bus.
  localparam int           ADDR_W          = 5;
  localparam logic [4:0]   ADDR_DATA_LOW   = 5'h00;
  localparam logic [4:0]   ADDR_DATA_HIGH  = 5'h04;
  localparam logic [4:0]   ADDR_CONTROL    = 5'h08;
  localparam logic [4:0]   ADDR_FLAGS      = 5'h0c;
  localparam logic [4:0]   ADDR_TRIGGER    = 5'h10;

  // Bit positions inside the flag and trigger registers.
  localparam int           FLAG_DONE_BIT   = 0;
  localparam int           TRIGGER_BIT     = 0;
  localparam int           BUSY_BIT        = 0;

  // Reset values.
  localparam logic [3:0]   CONTROL_RESET   = 4'h0;
  localparam logic [7:0]   DATA_RESET      = 8'h00;

  // Clock source code that hands the shift clock to the remote device.
  localparam logic [1:0]   SRC_EXTERNAL    = 2'b11;

  // System clock rate in MHz, and half periods of the master shift clock in system clock cycles.
  localparam int           CLK_MHZ         = 200;
  localparam logic [15:0]  HALF_DIV_FAST   = 16'h0008;
  localparam logic [15:0]  HALF_DIV_MID    = 16'h0020;
  localparam logic [15:0]  HALF_DIV_SLOW   = 16'h0080;

  // Serial port control register layout.
  typedef struct packed {
    logic src_high;
    logic src_low;
    logic edge_sel;
    logic done_mask;
  } ctrl_t;

  // Link pins as seen after synchronisation.
  typedef struct packed {
    logic sclk;
    logic sdi;
  } link_in_t;

endpackage : csp_pkg

// ---- hdl/serial_shift_reg.sv ----
// Eight-bit shift register of the serial port, loaded in nibbles, shifted LSB first.
`timescale 1ns/1ps
`default_nettype none
module serial_shift_reg #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // Nibble loads from the register bus
  input  wire logic             load_low_i,
  input  wire logic             load_high_i,
  input  wire logic [3:0]       nibble_i,
  // Shift control
  input  wire logic             out_step_i,
  input  wire logic             sample_i,
  input  wire logic             sdi_i,
  // Results
  output logic      [WIDTH-1:0] data_o,
  output logic                  sdo_o
);

  if (WIDTH != 8)
  begin : g_width_check
    $error("serial_shift_reg supports only WIDTH of 8");
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      data_o <= csp_pkg::DATA_RESET;
    end
    else if (load_low_i)
    begin
      data_o[3:0] <= nibble_i;
    end
    else if (load_high_i)
    begin
      data_o[7:4] <= nibble_i;
    end
    else if (sample_i)
    begin
      data_o <= {sdi_i, data_o[WIDTH-1:1]};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sdo_o <= 1'b1;
    end
    else if (out_step_i)
    begin
      sdo_o <= data_o[0];
    end
  end

endmodule : serial_shift_reg
`default_nettype wire

// ---- sim/clocked_serial_port_control_assertions.sv ----
// Concurrent checks on the serial port's bus, interrupt and link pins.
`timescale 1ns/1ps
`default_nettype none
module csp_assertions (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        srst_i,
  // Register bus
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Interrupt and link
  input wire logic        irq_o,
  input wire logic        sclk_o,
  input wire logic        sclk_oe_n_o,
  input wire logic        sdo_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire logic req = avs_read_i | avs_write_i;
  sequence bus_take;
    req && !avs_waitrequest_o;
  endsequence
  sequence flag_read;
    bus_take ##0 (avs_read_i && avs_address_i == csp_pkg::ADDR_FLAGS);
  endsequence
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("no wait cycle at request start");
  a_one_wait: assert property ($rose(req) |=> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  a_idle_no_wait: assert property (!req |-> !avs_waitrequest_o)
    else $error("wait raised without request");
  a_upper_zero: assert property (bus_take |-> avs_readdata_o[31:4] == 28'h0000000)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property (bus_take ##0 (avs_read_i && avs_address_i > 5'h10)
    |-> avs_readdata_o == 32'h00000000) else $error("unmapped read not zero");
  a_flag_read_clear: assert property (flag_read |=> !irq_o)
    else $error("interrupt still high after flag read");
  a_half_period: assert property (!sclk_oe_n_o && $changed(sclk_o) |=> $stable(sclk_o)[*7])
    else $error("shift clock half period too short");
  a_reset_idle: assert property ($fell(srst_i) |-> sdo_o && sclk_o && sclk_oe_n_o && !irq_o)
    else $error("link pins not idle after reset");
endmodule : csp_assertions
bind clocked_serial_port_control csp_assertions u_csp_assertions (.*);
`default_nettype wire

// ---- sim/remote_serial_device.sv ----
// Remote serial device: shifts a byte out on sdi and captures sdo, LSB first.
`timescale 1ns/1ps
`default_nettype none
module remote_serial_device (
  // Link
  input  wire logic sclk_i,
  input  wire logic sdo_i,
  output logic      ext_clk_o,
  output logic      sdi_o
);
  logic [7:0] tx = 8'h3c;
  logic [7:0] rx;
  logic [2:0] idx;
  logic       pol = 1'b0;
  // Polarity follows the port's edge select, so that the same edges drive and capture.
  wire        norm_sclk = sclk_i ^ pol;
  initial ext_clk_o = 1'b1;
  initial sdi_o = 1'b0;
  always @(negedge norm_sclk) sdi_o <= tx[idx];
  always @(negedge norm_sclk) idx <= idx + 3'h1;
  always @(posedge norm_sclk) rx <= {sdo_i, rx[7:1]};
  // Clock stands still until asked; pulses only when asked, after the trigger or, for the idle edges, after an abort.
  task automatic run(input int n);
    idx = 3'h0;
    repeat (n)
    begin
      #80 ext_clk_o = 1'b0;
      #80 ext_clk_o = 1'b1;
    end
  endtask : run
  task automatic polarity(input logic p);
    pol = p;
  endtask : polarity
endmodule : remote_serial_device
`default_nettype wire

// ---- sim/clocked_serial_port_control_bench.sv ----
// Self-checking bench for the clocked serial port with a remote device model.
`timescale 1ns/1ps
`default_nettype none
module clocked_serial_port_control_bench;
  logic        clk_i;
  logic        srst_i;
  logic [4:0]  adr;
  logic        rd_s;
  logic        wr_s;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wait_r;
  logic        irq;
  logic        sclk_out;
  logic        oe_n;
  logic        sdo;
  logic        sdi;
  logic        ext_clk;
  logic        sclk_line;
  logic [31:0] val;
  int          errors;
  int          comparisons;
  assign sclk_line = oe_n ? ext_clk : sclk_out;
  clocked_serial_port_control u_clocked_serial_port_control (
    .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r), .irq_o(irq),
    .sclk_i(sclk_line), .sclk_o(sclk_out), .sclk_oe_n_o(oe_n), .sdi_i(sdi), .sdo_o(sdo));
  remote_serial_device u_remote_serial_device (
    .sclk_i(sclk_line), .sdo_i(sdo), .ext_clk_o(ext_clk), .sdi_o(sdi));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [3:0] d);
    @(posedge clk_i);
    adr   <= a;
    wdata <= {28'h0000000, d};
    wr_s  <= w;
    rd_s  <= ~w;
    @(posedge clk_i);
    while (wait_r !== 1'b0) @(posedge clk_i);
    val = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 4'h0);
    chk(n, val, e);
  endtask : rdc
  task automatic go(input logic [3:0] lo, input logic [3:0] hi);
    bus(1'b1, csp_pkg::ADDR_DATA_LOW, lo);
    bus(1'b1, csp_pkg::ADDR_DATA_HIGH, hi);
    u_remote_serial_device.run(0);
    bus(1'b1, csp_pkg::ADDR_TRIGGER, 4'h1);
  endtask : go
  task automatic settle;
    do bus(1'b0, csp_pkg::ADDR_TRIGGER, 4'h0); while (val[0] !== 1'b0);
  endtask : settle
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    #200000;
    errors++;
    results();
  end
  initial
  begin
    srst_i = 1'b1;
    adr = 5'h00;
    rd_s = 1'b0;
    wr_s = 1'b0;
    wdata = 32'h00000000;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    rdc(csp_pkg::ADDR_CONTROL, 32'h0, "control reset");
    rdc(5'h14, 32'h0, "unmapped");
    bus(1'b1, csp_pkg::ADDR_TRIGGER, 4'h1);
    rdc(csp_pkg::ADDR_TRIGGER, 32'h0, "unarmed trigger");
    go(4'h5, 4'ha);
    rdc(csp_pkg::ADDR_TRIGGER, 32'h1, "busy");
    settle();
    chk("masked irq", irq, 1'b0);
    rdc(csp_pkg::ADDR_FLAGS, 32'h1, "done flag");
    rdc(csp_pkg::ADDR_FLAGS, 32'h0, "flag cleared");
    rdc(csp_pkg::ADDR_DATA_LOW, 32'hc, "rx low");
    rdc(csp_pkg::ADDR_DATA_HIGH, 32'h3, "rx high");
    chk("remote rx", u_remote_serial_device.rx, 32'ha5);
    bus(1'b1, csp_pkg::ADDR_CONTROL, 4'h1);
    go(4'h1, 4'h8);
    settle();
    chk("irq", irq, 1'b1);
    rdc(csp_pkg::ADDR_FLAGS, 32'h1, "done flag");
    @(posedge clk_i);
    chk("irq cleared", irq, 1'b0);
    bus(1'b1, csp_pkg::ADDR_CONTROL, 4'hc);
    go(4'ha, 4'h5);
    chk("external drive", oe_n, 1'b1);
    u_remote_serial_device.run(8);
    settle();
    rdc(csp_pkg::ADDR_FLAGS, 32'h1, "ext done");
    chk("ext rx", u_remote_serial_device.rx, 32'h5a);
    go(4'h0, 4'h0);
    u_remote_serial_device.run(3);
    rdc(csp_pkg::ADDR_FLAGS, 32'h0, "abort flag");
    rdc(csp_pkg::ADDR_TRIGGER, 32'h0, "abort busy");
    u_remote_serial_device.run(5);
    rdc(csp_pkg::ADDR_FLAGS, 32'h0, "idle edges");
    bus(1'b1, csp_pkg::ADDR_CONTROL, 4'he);
    u_remote_serial_device.polarity(1'b1);
    bus(1'b1, csp_pkg::ADDR_CONTROL, 4'h6);
    go(4'h6, 4'h9);
    chk("master drive", oe_n, 1'b0);
    settle();
    chk("inverted idle clock", sclk_out, 1'b0);
    rdc(csp_pkg::ADDR_FLAGS, 32'h1, "mid done");
    chk("mid rx", u_remote_serial_device.rx, 32'h96);
    rdc(csp_pkg::ADDR_DATA_LOW, 32'hc, "mid rx low");
    rdc(csp_pkg::ADDR_DATA_HIGH, 32'h3, "mid rx high");
    bus(1'b1, csp_pkg::ADDR_CONTROL, 4'ha);
    go(4'h7, 4'he);
    settle();
    rdc(csp_pkg::ADDR_FLAGS, 32'h1, "slow done");
    chk("slow rx", u_remote_serial_device.rx, 32'he7);
    rdc(csp_pkg::ADDR_DATA_LOW, 32'hc, "slow rx low");
    rdc(csp_pkg::ADDR_DATA_HIGH, 32'h3, "slow rx high");
    results();
  end
endmodule : clocked_serial_port_control_bench
`default_nettype wire
